// ### src/start_out_pkg.sv
// Constants and types for the start trigger and output select block
package start_out_pkg;

	typedef enum logic [1:0] {
		TRIG_EDGE = 2'h0,
		TRIG_LEVEL = 2'h1,
		TRIG_FAST = 2'h2,
		TRIG_PULSE = 2'h3
	} trig_mode_t;

	localparam logic [4:0] SEL_READY = 5'h00;
	localparam logic [4:0] SEL_AT_FREQ = 5'h01;
	localparam logic [4:0] SEL_RUNNING = 5'h02;
	localparam logic [4:0] SEL_REVERSE = 5'h03;
	localparam logic [4:0] SEL_OVERLOAD = 5'h04;
	localparam logic [4:0] SEL_RAMP_REG = 5'h05;
	localparam logic [4:0] SEL_ABOVE_FREQ = 5'h06;
	localparam logic [4:0] SEL_ABOVE_CUR = 5'h07;
	localparam logic [4:0] SEL_ABOVE_BUS = 5'h08;
	localparam logic [4:0] SEL_RETRIES = 5'h09;
	localparam logic [4:0] SEL_ABOVE_ANLG = 5'h0A;
	localparam logic [4:0] SEL_ABOVE_PF = 5'h0B;
	localparam logic [4:0] SEL_ANLG_LOSS = 5'h0C;
	localparam logic [4:0] SEL_DIRECT = 5'h0D;
	localparam logic [4:0] SEL_NONREC = 5'h0E;
	localparam logic [4:0] SEL_BRAKE = 5'h0F;
	localparam logic [4:0] SEL_THERMAL = 5'h10;
	localparam logic [4:0] SEL_OVERHEAT = 5'h11;

	// Timing
	localparam int CLK_HZ = 200000000;
	localparam int FILTER_MS = 100;
	localparam int FAST_START_MS = 10;
	localparam int FILTER_CYC = CLK_HZ / 1000 * FILTER_MS;
	localparam int FAST_START_CYC = CLK_HZ / 1000 * FAST_START_MS;

	localparam logic [1:0] POL_RESET = 2'h0;

endpackage

// ### src/start_trigger_output_select.sv
// Two-wire start trigger modes and two programmable digital outputs
`timescale 1ns/1ps

module start_trigger_output_select
	import start_out_pkg::*;
#(
	parameter int FILTER_CYCLES = FILTER_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Contacts
	input wire logic stopOpen,
	input wire logic forwardRunInput,
	input wire logic reverseRunInput,
	// Configuration
	input wire logic twoWireSelected,
	input wire logic [1:0] triggerModeParam,
	input wire logic [4:0] outputOneSelectParam,
	input wire logic [4:0] outputTwoSelectParam,
	input wire logic [15:0] levelOne,
	input wire logic [15:0] levelTwo,
	input wire logic [1:0] polarity,
	// Status conditions from other drive functions
	input wire logic powerReady,
	input wire logic faultActive,
	input wire logic atFreqEnter,
	input wire logic atFreqLeave,
	input wire logic motorEnergised,
	input wire logic reverseCommanded,
	input wire logic motorOverload,
	input wire logic rampRegActive,
	input wire logic [1:0] freqAbove,
	input wire logic [1:0] currentAbove,
	input wire logic [1:0] busAbove,
	input wire logic retriesExceeded,
	input wire logic autoRestartOff,
	input wire logic unrecoverableFault,
	input wire logic [1:0] analogAbove,
	input wire logic [1:0] pfAngleAbove,
	input wire logic analogBelowLossOn,
	input wire logic analogAboveLossOff,
	input wire logic brakeEnergiseOutput,
	input wire logic thermalOverloadWarning,
	input wire logic nearOverheatTrip,
	input wire logic moduleOverheat,
	// Drive commands
	output logic runCommand,
	output logic runReverse,
	output logic coastStop,
	output logic rampStop,
	output logic stageReady,
	// Digital outputs
	output logic digitalOutputOne,
	output logic digitalOutputTwo
);

	//********************************************************
	// Reset and input synchronisers
	//********************************************************
	logic rstMeta_q, rstSync_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	logic [2:0] pinMeta_q, pinSync_q;
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			pinMeta_q <= 3'h1;
			pinSync_q <= 3'h1;
		end else begin
			pinMeta_q <= {reverseRunInput, forwardRunInput, stopOpen};
			pinSync_q <= pinMeta_q;
		end
	end
	logic stopAct, fwdIn, revIn;
	assign {revIn, fwdIn, stopAct} = pinSync_q;

	//********************************************************
	// Start trigger
	//********************************************************
	// Mode is latched only while stopped so a live change cannot glitch
	trig_mode_t mode_q, mode_d;
	logic run_q, run_d, rev_q, rev_d, fwdPrev_q, revPrev_q;
	logic fwdEdge, revEdge;
	assign fwdEdge = fwdIn && !fwdPrev_q;
	assign revEdge = revIn && !revPrev_q;
	always_comb begin
		mode_d = mode_q;
		run_d = run_q;
		rev_d = rev_q;
		if (!run_q) begin
			mode_d = trig_mode_t'(triggerModeParam);
		end
		if (!twoWireSelected) begin
			run_d = 1'b0;
		end else if (stopAct) begin
			run_d = 1'b0;
		end else begin
			unique case (mode_q)
				TRIG_EDGE, TRIG_FAST: begin
					if (fwdEdge || revEdge) begin
						run_d = 1'b1;
						rev_d = revEdge && !fwdEdge;
					end else if (!fwdIn && !revIn) begin
						run_d = 1'b0;
					end
				end
				TRIG_LEVEL: begin
					run_d = fwdIn || revIn;
					if (fwdIn || revIn) begin
						rev_d = revIn && !fwdIn;
					end
				end
				TRIG_PULSE: begin
					if (fwdEdge || revEdge) begin
						run_d = 1'b1;
						rev_d = revEdge && !fwdEdge;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			mode_q <= TRIG_EDGE;
			run_q <= 1'b0;
			rev_q <= 1'b0;
			fwdPrev_q <= 1'b0;
			revPrev_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			run_q <= run_d;
			rev_q <= rev_d;
			fwdPrev_q <= fwdIn;
			revPrev_q <= revIn;
		end
	end
	assign runCommand = run_q;
	assign runReverse = rev_q;
	assign coastStop = stopAct && mode_q != TRIG_PULSE;
	assign rampStop = stopAct && mode_q == TRIG_PULSE;
	// Stage held ready so a start lands well inside the fast window
	assign stageReady = twoWireSelected && mode_q == TRIG_FAST;

	//********************************************************
	// Output selection
	//********************************************************
	logic lossHold_q, lossHold_d, atFreq_q, atFreq_d;
	always_comb begin
		lossHold_d = lossHold_q;
		atFreq_d = atFreq_q;
		if (analogBelowLossOn) begin
			lossHold_d = 1'b1;
		end else if (analogAboveLossOff) begin
			lossHold_d = 1'b0;
		end
		if (atFreqEnter) begin
			atFreq_d = 1'b1;
		end else if (atFreqLeave) begin
			atFreq_d = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			lossHold_q <= 1'b0;
			atFreq_q <= 1'b0;
		end else begin
			lossHold_q <= lossHold_d;
			atFreq_q <= atFreq_d;
		end
	end
	logic [4:0] sel [2];
	logic [15:0] lvl [2];
	assign sel[0] = outputOneSelectParam;
	assign sel[1] = outputTwoSelectParam;
	assign lvl[0] = levelOne;
	assign lvl[1] = levelTwo;
	logic [1:0] raw, filt, outBit;
	logic [31:0] cnt_q [2];
	logic [31:0] cnt_d [2];
	logic [1:0] state_q, state_d;
	for (genvar i = 0; i < 2; i++) begin : g_out
		always_comb begin
			raw[i] = 1'b0;
			filt[i] = sel[i] inside {SEL_OVERLOAD, SEL_RAMP_REG,
				SEL_ABOVE_FREQ, SEL_ABOVE_CUR, SEL_ABOVE_BUS,
				SEL_ABOVE_ANLG, SEL_ABOVE_PF};
			unique case (sel[i])
				SEL_READY: raw[i] = powerReady && !faultActive;
				SEL_AT_FREQ: raw[i] = atFreq_q;
				SEL_RUNNING: raw[i] = motorEnergised;
				SEL_REVERSE: raw[i] = reverseCommanded;
				SEL_OVERLOAD: raw[i] = motorOverload;
				SEL_RAMP_REG: raw[i] = rampRegActive;
				SEL_ABOVE_FREQ: raw[i] = freqAbove[i];
				SEL_ABOVE_CUR: raw[i] = currentAbove[i];
				SEL_ABOVE_BUS: raw[i] = busAbove[i];
				SEL_RETRIES: raw[i] = retriesExceeded;
				SEL_ABOVE_ANLG: raw[i] = analogAbove[i];
				SEL_ABOVE_PF: raw[i] = pfAngleAbove[i];
				SEL_ANLG_LOSS: raw[i] = lossHold_q;
				SEL_DIRECT: raw[i] = lvl[i] != 16'h0000;
				SEL_NONREC: raw[i] = retriesExceeded || autoRestartOff
					|| unrecoverableFault;
				SEL_BRAKE: raw[i] = brakeEnergiseOutput;
				SEL_THERMAL: raw[i] = thermalOverloadWarning
					|| nearOverheatTrip;
				SEL_OVERHEAT: raw[i] = moduleOverheat;
				default: raw[i] = 1'b0;
			endcase
			// Any break in the new level restarts the delay
			cnt_d[i] = 32'h0;
			state_d[i] = raw[i];
			if (filt[i] && raw[i] != state_q[i]) begin
				state_d[i] = state_q[i];
				cnt_d[i] = cnt_q[i] + 32'h1;
				if (cnt_q[i] + 32'h1 >= 32'(FILTER_CYCLES)) begin
					state_d[i] = raw[i];
					cnt_d[i] = 32'h0;
				end
			end
		end
		always_ff @(posedge clk or negedge rstSync_q) begin
			if (!rstSync_q) begin
				cnt_q[i] <= 32'h0;
				state_q[i] <= 1'b0;
			end else begin
				cnt_q[i] <= cnt_d[i];
				state_q[i] <= state_d[i];
			end
		end
	end
	logic [1:0] pol_q;
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			pol_q <= POL_RESET;
		end else begin
			pol_q <= polarity;
		end
	end
	// Normally-closed inverts the sense per output
	assign outBit = state_q ^ pol_q;
	assign digitalOutputOne = outBit[0];
	assign digitalOutputTwo = outBit[1];

	//********************************************************
	// Checks
	//********************************************************
	property p_stop_clears;
		@(posedge clk) disable iff (!rstSync_q)
		stopAct |=> !runCommand;
	endproperty
	a_stop_clears: assert property (p_stop_clears)
		else $error("run still set after stop");
	property p_no_two_wire;
		@(posedge clk) disable iff (!rstSync_q)
		!twoWireSelected |=> !runCommand;
	endproperty
	a_no_two_wire: assert property (p_no_two_wire)
		else $error("run without two-wire source");
	property p_level_restart;
		@(posedge clk) disable iff (!rstSync_q)
		mode_q == TRIG_LEVEL && twoWireSelected && !stopAct && fwdIn
		|=> runCommand;
	endproperty
	a_level_restart: assert property (p_level_restart)
		else $error("held run did not restart");
	property p_edge_start;
		@(posedge clk) disable iff (!rstSync_q)
		mode_q == TRIG_EDGE && twoWireSelected && !stopAct && fwdEdge
		|=> runCommand;
	endproperty
	a_edge_start: assert property (p_edge_start)
		else $error("edge did not start");
	property p_pulse_stop;
		@(posedge clk) disable iff (!rstSync_q)
		mode_q == TRIG_PULSE && stopAct |-> rampStop && !coastStop;
	endproperty
	a_pulse_stop: assert property (p_pulse_stop)
		else $error("pulse mode stop wrong");
	property p_direct;
		@(posedge clk) disable iff (!rstSync_q)
		sel[0] == SEL_DIRECT && $stable(sel[0]) && $stable(pol_q)
		|=> digitalOutputOne == (($past(levelOne) != 16'h0000) ^ pol_q[0]);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct output wrong");
	property p_filter_hold;
		@(posedge clk) disable iff (!rstSync_q)
		filt[0] && $stable(sel[0]) && raw[0] != state_q[0]
		&& cnt_q[0] == 32'h0 |=> $stable(state_q[0]);
	endproperty
	a_filter_hold: assert property (p_filter_hold)
		else $error("filtered output changed early");
	property p_ready;
		@(posedge clk) disable iff (!rstSync_q)
		sel[1] == SEL_READY && faultActive |=> !state_q[1];
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready shown during fault");
	c_level: cover property (@(posedge clk) mode_q == TRIG_LEVEL
		&& runCommand);
	c_pulse: cover property (@(posedge clk) mode_q == TRIG_PULSE
		&& rampStop);
	c_filter: cover property (@(posedge clk) filt[0]
		&& $rose(state_q[0]));

endmodule

// ### bench/contact_panel.sv
// Operator contact panel model: stop and run contacts
`timescale 1ns/1ps

module contact_panel (
	// Clock
	input wire logic clk,
	// Contacts
	output logic stopOpen,
	output logic fwdRun,
	output logic revRun
);
	initial begin
		stopOpen = 1'b0;
		fwdRun = 1'b0;
		revRun = 1'b0;
	end

	// Contacts move at falling edges only, clear of sampling
	task automatic setContacts(input logic s, input logic f, input logic r);
		@(negedge clk);
		stopOpen = s;
		fwdRun = f;
		revRun = r;
	endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for start trigger and output select
`timescale 1ns/1ps

module testbench
	import start_out_pkg::*;
;
	localparam int FILT = 8;
	// Selections with on/off delay
	localparam logic [17:0] FILT_SEL = 18'h00DF0;
	logic clk = 1'b0;
	logic rstN = 1'b0;
	logic twoWire = 1'b1;
	logic [1:0] mode = TRIG_EDGE;
	logic [4:0] sel = 5'h00;
	logic [17:0] cond = 18'h00000;
	logic [1:0] pol = 2'h0;
	logic fault = 1'b0;
	logic autoOff = 1'b0;
	logic nearTrip = 1'b0;
	logic stopOpen, fwdRun, revRun;
	logic runCmd, runRev, coast, ramp, ready, outOne, outTwo;
	int err_total = 0;
	int num_checks = 0;

	always #2.5 clk = ~clk;

	contact_panel panel_u (.clk(clk), .stopOpen(stopOpen),
		.fwdRun(fwdRun), .revRun(revRun));

	start_trigger_output_select #(.FILTER_CYCLES(FILT)) dut_u (
		.clk(clk), .rst_n(rstN), .stopOpen(stopOpen),
		.forwardRunInput(fwdRun), .reverseRunInput(revRun),
		.twoWireSelected(twoWire), .triggerModeParam(mode),
		.outputOneSelectParam(sel), .outputTwoSelectParam(sel),
		.levelOne({15'h0000, cond[13]}), .levelTwo({15'h0000, cond[13]}),
		.polarity(pol), .powerReady(cond[0]), .faultActive(fault),
		.atFreqEnter(cond[1]), .atFreqLeave(!cond[1]),
		.motorEnergised(cond[2]), .reverseCommanded(cond[3]),
		.motorOverload(cond[4]), .rampRegActive(cond[5]),
		.freqAbove({2{cond[6]}}), .currentAbove({2{cond[7]}}),
		.busAbove({2{cond[8]}}), .retriesExceeded(cond[9]),
		.autoRestartOff(autoOff), .unrecoverableFault(cond[14]),
		.analogAbove({2{cond[10]}}), .pfAngleAbove({2{cond[11]}}),
		.analogBelowLossOn(cond[12]), .analogAboveLossOff(!cond[12]),
		.brakeEnergiseOutput(cond[15]), .thermalOverloadWarning(cond[16]),
		.nearOverheatTrip(nearTrip), .moduleOverheat(cond[17]),
		.runCommand(runCmd), .runReverse(runRev), .coastStop(coast),
		.rampStop(ramp), .stageReady(ready),
		.digitalOutputOne(outOne), .digitalOutputTwo(outTwo));

	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Mode is only changed with all contacts released
	task automatic setMode(input logic [1:0] m);
		panel_u.setContacts(1'b0, 1'b0, 1'b0);
		cyc(4);
		mode = m;
		cyc(2);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		err_total++;
		conclude();
	end

	initial begin
		cyc(5);
		chk(coast, 1'b1);
		chk(runCmd, 1'b0);
		rstN = 1'b1;
		cyc(4);
		// Edge mode: a held run does not restart after stop
		panel_u.setContacts(1'b0, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b1);
		chk(runRev, 1'b0);
		panel_u.setContacts(1'b1, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b0);
		panel_u.setContacts(1'b0, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b0);
		$display("edge mode done");
		setMode(TRIG_LEVEL);
		panel_u.setContacts(1'b0, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b1);
		panel_u.setContacts(1'b1, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b0);
		chk(coast, 1'b1);
		panel_u.setContacts(1'b0, 1'b1, 1'b0);
		cyc(4);
		chk(runCmd, 1'b1);
		twoWire = 1'b0;
		cyc(4);
		chk(runCmd, 1'b0);
		twoWire = 1'b1;
		$display("level mode done");
		setMode(TRIG_FAST);
		chk(ready, 1'b1);
		panel_u.setContacts(1'b0, 1'b0, 1'b1);
		cyc(4);
		chk(runCmd, 1'b1);
		chk(runRev, 1'b1);
		panel_u.setContacts(1'b1, 1'b0, 1'b1);
		cyc(4);
		chk(coast, 1'b1);
		chk(runCmd, 1'b0);
		$display("fast mode done");
		setMode(TRIG_PULSE);
		chk(ready, 1'b0);
		panel_u.setContacts(1'b0, 1'b0, 1'b1);
		panel_u.setContacts(1'b0, 1'b0, 1'b0);
		cyc(4);
		chk(runCmd, 1'b1);
		chk(runRev, 1'b1);
		panel_u.setContacts(1'b1, 1'b0, 1'b0);
		cyc(4);
		chk(ramp, 1'b1);
		chk(coast, 1'b0);
		chk(runCmd, 1'b0);
		panel_u.setContacts(1'b0, 1'b1, 1'b0);
		panel_u.setContacts(1'b0, 1'b0, 1'b0);
		cyc(4);
		chk(runCmd, 1'b1);
		chk(runRev, 1'b0);
		$display("pulse mode done");
		// Every selection: idle low, then condition raised
		for (int s = 0; s <= 17; s++) begin
			sel = 5'(s);
			cond = 18'h00000;
			cyc(FILT + 4);
			chk(outOne, 1'b0);
			cond[s] = 1'b1;
			if (FILT_SEL[s]) begin
				cyc(4);
				chk(outTwo, 1'b0);
				cyc(FILT);
			end else begin
				cyc(2);
			end
			chk(outOne, 1'b1);
			chk(outTwo, 1'b1);
		end
		// A break in the condition restarts the delay
		sel = SEL_OVERLOAD;
		cond = 18'h00000;
		cyc(FILT + 2);
		cond[4] = 1'b1;
		cyc(FILT - 2);
		cond[4] = 1'b0;
		cyc(1);
		cond[4] = 1'b1;
		cyc(FILT - 2);
		chk(outOne, 1'b0);
		cyc(2);
		chk(outOne, 1'b1);
		sel = SEL_READY;
		cond = 18'h00001;
		cyc(2);
		fault = 1'b1;
		cyc(2);
		chk(outOne, 1'b0);
		fault = 1'b0;
		sel = SEL_NONREC;
		cond = 18'h00000;
		autoOff = 1'b1;
		cyc(2);
		chk(outOne, 1'b1);
		autoOff = 1'b0;
		sel = SEL_THERMAL;
		cyc(2);
		chk(outOne, 1'b0);
		nearTrip = 1'b1;
		cyc(2);
		chk(outOne, 1'b1);
		nearTrip = 1'b0;
		sel = SEL_OVERHEAT;
		cond = 18'h20000;
		pol = 2'h1;
		cyc(3);
		chk(outOne, 1'b0);
		chk(outTwo, 1'b1);
		pol = 2'h2;
		cyc(3);
		chk(outOne, 1'b1);
		chk(outTwo, 1'b0);
		$display("outputs done");
		conclude();
	end
endmodule
